// *** evctr_channel.sv ***
// timer channel: external event counter and channel 0 frequency divider, APB slave
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module evctr_channel (
    input  wire logic        CLK,               // 20 MHz system clock
    input  wire logic        RSTN,              // async reset, active low
    input  wire logic        PSEL,              // APB select
    input  wire logic        PENABLE,           // APB access phase
    input  wire logic        PWRITE,            // APB direction
    input  wire logic [7:0]  PADDR,             // APB byte address
    input  wire logic [31:0] PWDATA,            // APB write data
    output logic      [31:0] PRDATA,            // APB read data
    output logic             PREADY,            // APB ready
    output logic             PSLVERR,           // APB error, unmapped address
    input  wire logic        TIMER_INPUT_PIN,   // external edge source
    output logic             TIMER_OUTPUT_PIN,  // divided / toggled output
    output logic             CHANNEL_INTERRUPT  // one-cycle interrupt pulse
);
    import evctr_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic        unit_en;      // unit_enable_bit
    logic        noise_filt;   // noise_filter_enable, stored only
    logic [7:0]  prescale;     // prescaler_select_reg
    mode_cfg_t   cfg;          // channel0_mode_config
    logic [15:0] data_reg;     // data_register
    logic [15:0] count;        // count_register
    out_ctl_t    outc;         // output control bits
    chan_state_t state;        // channel state
    logic [15:0] pre_cnt;      // free-running prescaler
    logic        ck0_tick;     // prescaler_output_zero tick
    logic        ck1_tick;     // prescaler_output_one tick
    logic        op_tick;      // selected operation clock tick
    logic        edge_hit;     // valid input edge
    logic        cnt_evt;      // count clock event
    logic        access;       // APB access phase waiting for ready
    logic        wr_fire;      // write takes effect this edge
    logic        wr_ok;        // write allowed while unit powered
    logic        addr_hit;     // address is mapped
    logic [31:0] rd_mux;       // read data selected by address
    logic        start_req;    // start trigger written
    logic        stop_req;     // stop trigger written
    chan_state_t next_state;   // next channel state
    logic [15:0] next_count;   // next counter value
    logic        next_irq;     // interrupt this cycle
    logic        next_toggle;  // output toggle this cycle

    // ----------------------------------------------------------------
    // APB handshake: one wait state, answer registered
    // ----------------------------------------------------------------
    assign access  = PSEL & PENABLE & ~PREADY;
    assign wr_fire = PSEL & PENABLE & PREADY & PWRITE;
    // writes outside the unit enable register are dropped while off
    assign wr_ok   = wr_fire & unit_en;

    // address decode and read data
    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = 32'h0000_0000;
        unique case (PADDR)
            OFS_UNIT:     rd_mux = {30'h0, noise_filt, unit_en};
            OFS_PRESCALE: rd_mux = {24'h0, prescale};
            OFS_MODE:     rd_mux = {16'h0, cfg};
            OFS_DATA:     rd_mux = {16'h0, data_reg};
            OFS_COUNT:    rd_mux = {16'h0, count};     // readable at any time
            OFS_TRIG:     rd_mux = 32'h0000_0000;      // triggers read zero
            OFS_STATUS:   rd_mux = {31'h0, state != ST_IDLE};
            OFS_OUTPUT:   rd_mux = {28'h0, outc};
            default:      addr_hit = 1'b0;
        endcase
    end

    // ready rises one cycle into the access phase
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= access;
        end
    end

    // read data and error captured alongside ready
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (access) begin
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
            PSLVERR <= ~addr_hit;
        end else begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // unit enable: the only register writable while the unit is off
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            unit_en    <= 1'b0;
            noise_filt <= 1'b0;
        end else if (wr_fire && PADDR == OFS_UNIT) begin
            unit_en    <= PWDATA[UNIT_EN_BIT];
            noise_filt <= PWDATA[NOISE_FILT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // configuration registers, cleared while the unit is off
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            prescale <= PRESCALE_RESET;
            cfg      <= MODE_RESET;
            data_reg <= DATA_RESET;
        end else if (!unit_en) begin
            prescale <= PRESCALE_RESET;
            cfg      <= MODE_RESET;
            data_reg <= DATA_RESET;
        end else if (wr_ok) begin
            // data may change at any time; the counter only sees it when it loads at start or first count clock, or reloads
            if (PADDR == OFS_PRESCALE) prescale <= PWDATA[7:0];
            if (PADDR == OFS_MODE)     cfg      <= PWDATA[15:0] & MODE_WR_MASK;
            if (PADDR == OFS_DATA)     data_reg <= PWDATA[15:0];
        end
    end

    // ----------------------------------------------------------------
    // prescaler and operation clock select
    // ----------------------------------------------------------------
    // a tick every 2^n system clocks, n taken from the exponent field
    function automatic logic tick_at(input logic [15:0] cnt, input logic [3:0] expo);
        logic [15:0] mask;
        mask    = 16'((17'h1 << expo) - 17'h1);
        tick_at = (cnt & mask) == mask;
    endfunction

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_cnt <= 16'h0000;
        end else if (!unit_en) begin
            pre_cnt <= 16'h0000; // clock of the unit stands still
        end else begin
            pre_cnt <= pre_cnt + 16'h0001;
        end
    end

    assign ck0_tick = unit_en & tick_at(pre_cnt, prescale[PRE_CK0_LSB +: PRE_W]);
    assign ck1_tick = unit_en & tick_at(pre_cnt, prescale[PRE_CK1_LSB +: PRE_W]);
    // codes other than CK1 fall back on CK0
    assign op_tick  = (cfg.op_clock == OPCLK_CK1) ? ck1_tick : ck0_tick;

    // ----------------------------------------------------------------
    // input pin edge sensing
    // ----------------------------------------------------------------
    evctr_edge_sense u_edge (
        .CLK      (CLK),
        .RSTN     (RSTN),
        .CLR      (~unit_en),
        .PIN      (TIMER_INPUT_PIN),
        .TICK     (op_tick),
        .SEL      (cfg.edge_sel),
        .EDGE_HIT (edge_hit)
    );

    // counting source: pin edges or the operation clock itself
    assign cnt_evt = cfg.count_clock ? edge_hit : op_tick;

    // ----------------------------------------------------------------
    // triggers: self-clearing, never stored
    // ----------------------------------------------------------------
    assign start_req = wr_ok && PADDR == OFS_TRIG && PWDATA[TRIG_START_BIT];
    assign stop_req  = wr_ok && PADDR == OFS_TRIG && PWDATA[TRIG_STOP_BIT];

    // ----------------------------------------------------------------
    // channel sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_state  = state;
        next_count  = count;
        next_irq    = 1'b0;
        next_toggle = 1'b0;
        if (stop_req) begin
            // stop wins over a start in the same write; count is held
            next_state = ST_IDLE;
        end else if (start_req) begin
            if (cfg.mode == MD_EVENT) begin
                next_state = ST_COUNT;
                next_count = data_reg;  // loaded at once, edges awaited
            end else begin
                next_state = ST_WAIT_FIRST;
            end
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_WAIT_FIRST: begin
                    if (cnt_evt) begin
                        next_state  = ST_COUNT;
                        next_count  = data_reg;
                        next_irq    = cfg.start_behaviour;
                        next_toggle = cfg.start_behaviour;
                    end
                end
                ST_COUNT: begin
                    if (cnt_evt) begin
                        if (count == 16'h0000) begin
                            // data+1 count clocks per period
                            next_count  = data_reg;
                            next_irq    = 1'b1;
                            next_toggle = 1'b1;
                        end else begin
                            next_count = count - 16'h0001;
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE; // illegal code recovers stopped
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state             <= ST_IDLE;
            count             <= COUNT_RESET;
            CHANNEL_INTERRUPT <= 1'b0;
        end else if (!unit_en) begin
            state             <= ST_IDLE;
            count             <= COUNT_RESET;
            CHANNEL_INTERRUPT <= 1'b0;
        end else begin
            state             <= next_state;
            count             <= next_count;
            CHANNEL_INTERRUPT <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // output control and pin
    // ----------------------------------------------------------------
    // hardware toggles only when the output is enabled; software write wins
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            outc <= OUTPUT_RESET;
        end else if (!unit_en) begin
            outc <= OUTPUT_RESET;
        end else if (wr_ok && PADDR == OFS_OUTPUT) begin
            outc <= PWDATA[3:0];
        end else if (next_toggle && outc.out_enable) begin
            outc.out_value <= ~outc.out_value;
        end
    end

    // level bit chooses the driven polarity of the output value
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            TIMER_OUTPUT_PIN <= 1'b0;
        end else begin
            TIMER_OUTPUT_PIN <= outc.out_value ^ outc.out_level;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    chk_start_sets_flag: assert property (start_req && !stop_req |=> state != ST_IDLE)
        else $error("start did not raise enable flag");
    chk_stop_clears_flag: assert property (stop_req |=> state == ST_IDLE && count == $past(count))
        else $error("stop did not halt and hold count");
    chk_event_load_now: assert property (start_req && !stop_req && cfg.mode == MD_EVENT
        |=> count == $past(data_reg))
        else $error("event start did not load data");
    chk_count_down: assert property (unit_en && !start_req && !stop_req && state == ST_COUNT
        && cnt_evt && count != 16'h0000 |=> count == $past(count) - 16'h0001)
        else $error("counter did not decrement");
    chk_zero_reload: assert property (unit_en && !start_req && !stop_req && state == ST_COUNT
        && cnt_evt && count == 16'h0000 |=> CHANNEL_INTERRUPT && count == $past(data_reg))
        else $error("no reload or interrupt at zero");
    chk_irq_cause: assert property (CHANNEL_INTERRUPT |-> $past(cnt_evt) && $past(state) != ST_IDLE)
        else $error("interrupt without count event");
    chk_first_gate: assert property (unit_en && !start_req && !stop_req && state == ST_WAIT_FIRST
        && cnt_evt |=> CHANNEL_INTERRUPT == $past(cfg.start_behaviour))
        else $error("first edge interrupt wrong");
    chk_unit_off_reset: assert property (!unit_en |=> state == ST_IDLE && count == 16'h0000
        && data_reg == 16'h0000 && !CHANNEL_INTERRUPT)
        else $error("unit off did not reset channel");
    chk_toggle_pin: assert property (unit_en && next_toggle && outc.out_enable && !wr_ok
        |=> ##1 TIMER_OUTPUT_PIN != $past(TIMER_OUTPUT_PIN))
        else $error("output pin did not toggle");
    chk_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready not given after one wait");

    // ----------------------------------------------------------------
    // guards on data writes, stopped, waiting and powered-off states, the prohibited edge code and trigger/status reads
    // ----------------------------------------------------------------
    // a data write alone leaves the running count untouched
    chk_data_defer: assert property (wr_ok && PADDR == OFS_DATA && !cnt_evt |=> count == $past(count))
        else $error("data write disturbed the count");
    // a stopped channel holds its count until started or powered off
    chk_idle_hold: assert property (unit_en && state == ST_IDLE && !start_req |=> count == $past(count))
        else $error("stopped channel changed its count");
    // a divider start waits for the first edge before loading
    chk_divider_start: assert property (start_req && !stop_req && cfg.mode != MD_EVENT
        |=> state == ST_WAIT_FIRST && count == $past(count))
        else $error("divider start did not wait for first edge");
    // no count event means no load while waiting
    chk_wait_hold: assert property (unit_en && state == ST_WAIT_FIRST && !cnt_evt
        && !start_req && !stop_req |=> state == ST_WAIT_FIRST && count == $past(count))
        else $error("first edge wait left without an edge");
    // the prohibited edge code never counts
    chk_edge_none: assert property (&cfg.edge_sel |=> !edge_hit)
        else $error("edge seen with prohibited edge code");
    // trigger register always reads back zero
    chk_trig_zero: assert property (PREADY && !PWRITE && PADDR == OFS_TRIG |-> PRDATA == 32'h0000_0000)
        else $error("trigger register read nonzero");
    // status bit shows whether the channel ran when the read was taken
    chk_status_flag: assert property (PREADY && !PWRITE && PADDR == OFS_STATUS
        |-> PRDATA[STAT_EN_BIT] == $past(state != ST_IDLE))
        else $error("status flag disagrees with channel state");
    // powered off: prescaler stands still and no edge gets through
    chk_off_quiet: assert property (!unit_en |=> pre_cnt == 16'h0000 && !edge_hit)
        else $error("unit clock ran while powered off");
    // powered off: a mode write is dropped
    chk_off_no_write: assert property (!unit_en && wr_fire && PADDR == OFS_MODE |=> cfg == MODE_RESET)
        else $error("mode written while unit off");

    // cover points for the main scenarios
    cov_event_wrap:  cover property (cfg.mode == MD_EVENT && CHANNEL_INTERRUPT);
    cov_div_toggle:  cover property (cfg.count_clock && next_toggle && outc.out_enable);
    cov_stop_hold:   cover property (stop_req ##1 state == ST_IDLE && count != 16'h0000);
    cov_both_edges:  cover property (cfg.edge_sel == EDGE_BOTH && edge_hit);
    cov_first_quiet: cover property (state == ST_WAIT_FIRST && cnt_evt && !cfg.start_behaviour);

endmodule // evctr_channel

// *** evctr_edge_sense.sv ***
// input pin synchroniser and valid edge detector
`timescale 1ns/1ps
module evctr_edge_sense (
    input  wire logic       CLK,      // system clock
    input  wire logic       RSTN,     // async reset, active low
    input  wire logic       CLR,      // unit disabled: drop sampled state
    input  wire logic       PIN,      // raw timer_input_pin
    input  wire logic       TICK,     // operation clock tick
    input  wire logic [1:0] SEL,      // edge_select_field
    output logic            EDGE_HIT  // one-cycle valid edge pulse
);
    import evctr_pkg::*;

    logic sync1;   // first stage, read by sync2 only
    logic sync2;   // synchronised pin level
    logic sampled; // level seen at last operation clock tick
    logic rise;    // rising edge at this tick
    logic fall;    // falling edge at this tick

    // ----------------------------------------------------------------
    // two-stage synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= PIN;
            sync2 <= sync1;
        end
    end

    // ----------------------------------------------------------------
    // sampling on operation clock ticks; costs up to one tick of jitter
    // ----------------------------------------------------------------
    assign rise = TICK & sync2 & ~sampled;
    assign fall = TICK & ~sync2 & sampled;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sampled <= 1'b0;
        end else if (CLR) begin
            sampled <= sync2;
        end else if (TICK) begin
            sampled <= sync2;
        end
    end

    // ----------------------------------------------------------------
    // edge selection; prohibited code never fires
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            EDGE_HIT <= 1'b0;
        end else if (CLR) begin
            EDGE_HIT <= 1'b0;
        end else begin
            unique case (SEL)
                EDGE_FALL: EDGE_HIT <= fall;
                EDGE_RISE: EDGE_HIT <= rise;
                EDGE_BOTH: EDGE_HIT <= rise | fall;
                default:   EDGE_HIT <= 1'b0;
            endcase
        end
    end

endmodule // evctr_edge_sense

// *** evctr_edge_src.sv ***
// external edge source model driving the timer input pin
`timescale 1ns/1ps
module evctr_edge_src (
    input  wire logic CLK,  // system clock
    output logic      PIN   // timer_input_pin
);
    // ------------------------------------------
    // pulse train, idle low between bursts
    // ------------------------------------------
    initial PIN = 1'b0;
    // each pulse gives one rise and one fall, four clocks per level
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge CLK);
            PIN <= 1'b1;
            repeat (4) @(posedge CLK);
            PIN <= 1'b0;
        end
        repeat (8) @(posedge CLK); // let sync and count settle
    endtask
endmodule // evctr_edge_src

// *** evctr_pkg.sv ***
// constants, field layouts and types shared by the event counter / divider channel
// Function
// - interrupt once per data value plus one edges
// - count register counts downward in event mode
// - start trigger loads count, reads back zero
// - at zero reload from data, raise interrupt
// - new data value used from next reload
// - start sets enable flag, then awaits edges
// - stop clears enable flag, count held
// - unit off: no writes; on: channels stopped
// - unit off resets every channel register
// - single edge: divide by twice data plus one
// - both edges: divide by data plus one
// - divider loads count at first valid edge
// - start behaviour bit gates first interrupt, toggle
// - divider toggles output and reloads at zero
// - output period jitters by one operation clock
// - edge field: fall, rise, both; 11 prohibited
// - count clock select picks input pin edges
// - operation clock field picks prescaler output
// - output level bit sets output pin level
package evctr_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_UNIT     = 8'h00; // unit enable, noise filter
    localparam logic [7:0] OFS_PRESCALE = 8'h04; // prescaler_select_reg
    localparam logic [7:0] OFS_MODE     = 8'h08; // channel0_mode_config
    localparam logic [7:0] OFS_DATA     = 8'h0c; // data_register
    localparam logic [7:0] OFS_COUNT    = 8'h10; // count_register, read only
    localparam logic [7:0] OFS_TRIG     = 8'h14; // start / stop triggers
    localparam logic [7:0] OFS_STATUS   = 8'h18; // channel status
    localparam logic [7:0] OFS_OUTPUT   = 8'h1c; // output value/enable/level/mode

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int UNIT_EN_BIT    = 0; // unit_enable_bit
    localparam int NOISE_FILT_BIT = 1; // noise_filter_enable
    localparam int TRIG_START_BIT = 0; // start_trigger_bit
    localparam int TRIG_STOP_BIT  = 1; // stop_trigger_bit
    localparam int STAT_EN_BIT    = 0; // enable_status_flag
    localparam int PRE_CK0_LSB    = 0; // prescaler_output_zero exponent
    localparam int PRE_CK1_LSB    = 4; // prescaler_output_one exponent
    localparam int PRE_W          = 4; // width of each exponent field

    // ----------------------------------------------------------------
    // reset values and masks
    // ----------------------------------------------------------------
    localparam logic [15:0] MODE_RESET     = 16'h0000;
    localparam logic [15:0] MODE_WR_MASK   = 16'hdfcf; // reserved bits 13, 5, 4
    localparam logic [15:0] DATA_RESET     = 16'h0000;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [7:0]  PRESCALE_RESET = 8'h00;
    localparam logic [3:0]  OUTPUT_RESET   = 4'h0;

    // ----------------------------------------------------------------
    // field codes
    // ----------------------------------------------------------------
    localparam logic [1:0] EDGE_FALL   = 2'h0;
    localparam logic [1:0] EDGE_RISE   = 2'h1;
    localparam logic [1:0] EDGE_BOTH   = 2'h2;
    localparam logic [1:0] OPCLK_CK0   = 2'h0;
    localparam logic [1:0] OPCLK_CK1   = 2'h2;
    localparam logic [2:0] MD_INTERVAL = 3'h0; // interval / divider
    localparam logic [2:0] MD_EVENT    = 3'h3; // external event counter

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] op_clock;        // operation_clock_field
        logic       rsv13;           // reserved
        logic       count_clock;     // count_clock_select
        logic       master;          // slave_master_select
        logic [2:0] start_source;    // start_source_field
        logic [1:0] edge_sel;        // edge_select_field
        logic [1:0] rsv54;           // reserved
        logic [2:0] mode;            // operation mode
        logic       start_behaviour; // start_behaviour_bit
    } mode_cfg_t;

    typedef struct packed {
        logic out_mode;   // output_mode_bit
        logic out_level;  // output_level_bit
        logic out_enable; // output_enable_bit
        logic out_value;  // timer output value
    } out_ctl_t;

    typedef enum logic [1:0] {
        ST_IDLE       = 2'b00, // stopped
        ST_WAIT_FIRST = 2'b01, // started, load at first count clock
        ST_COUNT      = 2'b11  // counting down
    } chan_state_t;

endpackage

// *** testbench.sv ***
// self-checking bench for the event counter / divider channel
`timescale 1ns/1ps
module testbench;
    import evctr_pkg::*;
    logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, q;
    logic        pready, perr, pout, irq, pin, err;
    int          error_cnt = 0, n_checks = 0, irq_n = 0, tg = 0;
    always #25 clk = ~clk;
    // interrupt pulses and output pin changes
    always @(posedge clk) if (irq === 1'b1) irq_n++;
    always @(pout) tg++;
    evctr_channel i_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr),
        .TIMER_INPUT_PIN(pin), .TIMER_OUTPUT_PIN(pout), .CHANNEL_INTERRUPT(irq));
    evctr_edge_src i_src (.CLK(clk), .PIN(pin));
    // -------------------------------------
    // apb master, bounded wait on pready
    // -------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin error_cnt++; wrap_up; end
        q = prd; err = perr;
        psel <= 0; pen <= 0;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1;
        xfer(1, OFS_MODE, 32'h1046); xfer(0, OFS_MODE, 0); chk(q, 0); // write while off
        xfer(1, OFS_UNIT, 32'h3); // unit on, filter on
        xfer(1, OFS_OUTPUT, 0); // output off, master, level low
        xfer(1, OFS_MODE, 32'h1046); xfer(1, OFS_DATA, 2); xfer(1, OFS_TRIG, 1); // setup
        xfer(0, OFS_TRIG, 0); chk(q, 0); // trigger self clears
        xfer(0, OFS_COUNT, 0); chk(q, 2); // count loaded
        xfer(0, OFS_STATUS, 0); chk(q, 1); // running flag
        i_src.pulses(1); xfer(0, OFS_COUNT, 0); chk(q, 1); // counts down
        xfer(1, OFS_DATA, 4); i_src.pulses(2); chk(irq_n, 1); // one irq per period
        xfer(0, OFS_COUNT, 0); chk(q, 4); // reload takes new data
        $display("event test done");
        xfer(1, OFS_TRIG, 2); xfer(0, OFS_STATUS, 0); chk(q, 0); // stopped flag
        i_src.pulses(1); xfer(0, OFS_COUNT, 0); chk(q, 4); // count held
        xfer(1, OFS_UNIT, 0); xfer(1, OFS_UNIT, 1); xfer(0, OFS_DATA, 0); chk(q, 0); // cleared
        xfer(0, 8'h20, 0); chk(err, 1); // unmapped address flagged
        $display("stop and unit test done");
        xfer(1, OFS_OUTPUT, 2); xfer(1, OFS_MODE, 32'h1041); xfer(1, OFS_DATA, 1);
        irq_n = 0; tg = 0;
        xfer(1, OFS_TRIG, 1); i_src.pulses(5);
        chk(tg, 3); // divide by twice data plus one
        chk(irq_n, 3); // first edge irq with start bit set
        $display("divider test done");
        xfer(1, OFS_TRIG, 2); xfer(1, OFS_MODE, 32'h1080); irq_n = 0; tg = 0; // both edges, quiet start
        xfer(1, OFS_TRIG, 1); i_src.pulses(3); chk(tg, 2); // toggle every data plus one edges
        chk(irq_n, 2); // no interrupt at first edge load
        $display("both edge test done");
        wrap_up;
    end
endmodule // testbench
